/* hw/lsd_pkg.sv */
// Constants, types and helpers shared by the LED sink driver control logic.
package lsd_pkg;

   localparam int NCH           = 16;
   localparam int TRIM_W        = 7;
   localparam int ONOFF_LEN     = NCH;
   localparam int TRIM_LEN      = NCH * TRIM_W;
   localparam int CLK_PERIOD_NS = 50;
   localparam int STAGGER_NS    = 20;
   localparam int MAX_DLY       = ((NCH - 1) * STAGGER_NS) / CLK_PERIOD_NS;
   localparam int RST_STAGES    = 2;

   localparam int SYN_OUT_LOW   = 0;
   localparam int SYN_OVERTEMP  = NCH;
   localparam int SYN_STROBE    = NCH + 1;
   localparam int SYN_MODE      = NCH + 2;
   localparam int SYN_BLANK     = NCH + 3;
   localparam int SYN_W         = NCH + 4;

   localparam logic [ONOFF_LEN-1:0] ONOFF_RST = 16'h0000;
   localparam logic [TRIM_LEN-1:0]  TRIM_RST  = 112'h0;

   typedef enum logic {
      LSD_MODE_ONOFF = 1'b0,
      LSD_MODE_TRIM  = 1'b1
   } lsd_mode_e;

   // Cycles of the reference clock by which channel n lags channel 0.
   function automatic int lsd_dly(input int n);
      return (n * STAGGER_NS) / CLK_PERIOD_NS;
   endfunction

endpackage

/* hw/lsd_sync.sv */
// Two-stage synchroniser for a group of level inputs.
`timescale 1ns/1ps
`default_nettype none
module lsd_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lsd_sync_s;

   lsd_sync_s q;
   lsd_sync_s d;

   always_comb
   begin
      d    = q;
      d.s1 = i_d;
      d.s2 = q.s1;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         q <= '0;
      else
         q <= d;
   end

   assign o_q = q.s2;

endmodule // lsd_sync
`default_nettype wire

/* hw/lsd_link.sv */
// Serial shift registers running on the link shift clock.
`timescale 1ns/1ps
`default_nettype none
module lsd_link (
   input  wire logic                         i_shift_clk,
   input  wire logic                         i_rstn,
   input  wire logic                         i_mode,
   input  wire logic                         i_serial_in,
   output logic      [lsd_pkg::ONOFF_LEN-1:0] o_onoff_sr,
   output logic      [lsd_pkg::TRIM_LEN-1:0]  o_trim_sr,
   output logic                              o_serial_out
);

   typedef struct packed {
      logic [lsd_pkg::RST_STAGES-1:0] rs;
      logic [lsd_pkg::ONOFF_LEN-1:0]  onoff_sr;
      logic [lsd_pkg::TRIM_LEN-1:0]   trim_sr;
      logic                           serial_out;
   } lsd_link_s;

   lsd_link_s q;
   lsd_link_s d;

   always_comb
   begin
      d    = q;
      d.rs = {q.rs[lsd_pkg::RST_STAGES-2:0], 1'b1};
      if (q.rs[lsd_pkg::RST_STAGES-1])
      begin
         if (i_mode == lsd_pkg::LSD_MODE_TRIM)
         begin
            d.trim_sr = {q.trim_sr[lsd_pkg::TRIM_LEN-2:0], i_serial_in};
            d.serial_out    = q.trim_sr[lsd_pkg::TRIM_LEN-2];
         end
         else
         begin
            d.onoff_sr = {q.onoff_sr[lsd_pkg::ONOFF_LEN-2:0], i_serial_in};
            d.serial_out     = q.onoff_sr[lsd_pkg::ONOFF_LEN-2];
         end
      end
   end

   always_ff @(posedge i_shift_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end

   assign o_onoff_sr   = q.onoff_sr;
   assign o_trim_sr    = q.trim_sr;
   assign o_serial_out = q.serial_out;

   default clocking lk_cb @(posedge i_shift_clk);
   endclocking
   default disable iff (!q.rs[lsd_pkg::RST_STAGES-1]);

   a_shift_select: assert property (
      i_mode == lsd_pkg::LSD_MODE_ONOFF |=> $stable(q.trim_sr))
      else $error("Trim register moved in on/off mode.");

   a_trim_msb_first: assert property (
      i_mode == lsd_pkg::LSD_MODE_TRIM
      |=> q.trim_sr[0] == $past(i_serial_in) && q.serial_out == q.trim_sr[lsd_pkg::TRIM_LEN-1])
      else $error("Trim shift lost order or serial output.");

endmodule // lsd_link
`default_nettype wire

/* hw/lsd_top.sv */
// Control logic of the sixteen-channel LED sink driver.
`timescale 1ns/1ps
`default_nettype none
module lsd_top (
   input  wire logic                             i_ref_clk,
   input  wire logic                             i_rstn,
   input  wire logic                             i_shift_clk,
   input  wire logic                             i_serial_in,
   input  wire logic                             i_mode,
   input  wire logic                             i_latch_strobe,
   input  wire logic                             i_blank,
   input  wire logic                             i_overtemp_flag,
   input  wire logic      [lsd_pkg::NCH-1:0]      i_out_low,
   output logic                                  o_serial_out,
   output logic           [lsd_pkg::NCH-1:0]      o_sink_en,
   output logic           [lsd_pkg::TRIM_LEN-1:0] o_sink_trim,
   output logic                                  o_precharge_on,
   output logic                                  o_error_line_n_o,
   output logic                                  o_error_line_n_oe
);

   localparam int NCH  = lsd_pkg::NCH;
   localparam int TW   = lsd_pkg::TRIM_W;
   localparam int MAXD = lsd_pkg::MAX_DLY;

   typedef struct packed {
      logic                         strobe_prev;
      logic [lsd_pkg::ONOFF_LEN-1:0] onoff;
      logic [lsd_pkg::TRIM_LEN-1:0]  trim;
      logic [MAXD-1:0]              hist;
      logic [NCH-1:0]               sink_en;
      logic [lsd_pkg::TRIM_LEN-1:0]  sink_trim;
      logic                         precharge;
      logic                         err_oe;
   } lsd_top_s;

   lsd_top_s q;
   lsd_top_s d;

   logic [lsd_pkg::RST_STAGES-1:0] rst_q;
   logic                           rst_n;

   logic [lsd_pkg::SYN_W-1:0]     syn;
   logic                          blank_s;
   logic                          mode_s;
   logic                          strobe_s;
   logic                          overt_s;
   logic [NCH-1:0]                out_low_s;

   logic [lsd_pkg::ONOFF_LEN-1:0] lk_onoff;
   logic [lsd_pkg::TRIM_LEN-1:0]  lk_trim;

   logic [MAXD:0]                 hv;
   logic [NCH-1:0]                en_w;
   logic [NCH-1:0]                pend;
   logic [NCH-1:0]                open_led_flag;
   logic [lsd_pkg::TRIM_LEN-1:0]  trim_w;
   logic                          onoff_take;
   logic                          trim_take;

   // Reset release is held for two reference clock edges.
   always_ff @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         rst_q <= '0;
      else
         rst_q <= {rst_q[lsd_pkg::RST_STAGES-2:0], 1'b1};
   end

   assign rst_n = rst_q[lsd_pkg::RST_STAGES-1];

   lsd_sync #(
      .W (lsd_pkg::SYN_W)
   ) u_sync (
      .i_clk   (i_ref_clk),
      .i_rst_n (rst_n),
      .i_d     ({i_blank, i_mode, i_latch_strobe, i_overtemp_flag, i_out_low}),
      .o_q     (syn)
   );

   assign blank_s   = syn[lsd_pkg::SYN_BLANK];
   assign mode_s    = syn[lsd_pkg::SYN_MODE];
   assign strobe_s  = syn[lsd_pkg::SYN_STROBE];
   assign overt_s   = syn[lsd_pkg::SYN_OVERTEMP];
   assign out_low_s = syn[lsd_pkg::SYN_OUT_LOW +: NCH];

   lsd_link u_link (
      .i_shift_clk  (i_shift_clk),
      .i_rstn       (i_rstn),
      .i_mode       (i_mode),
      .i_serial_in  (i_serial_in),
      .o_onoff_sr   (lk_onoff),
      .o_trim_sr    (lk_trim),
      .o_serial_out (o_serial_out)
   );

   // The shift registers are only sampled while the strobe is high, when the
   // shift clock must stand still, so the words are stable as they cross.
   assign onoff_take = (mode_s == lsd_pkg::LSD_MODE_ONOFF) && strobe_s
                       && !q.strobe_prev;
   assign trim_take  = (mode_s == lsd_pkg::LSD_MODE_TRIM) && strobe_s;

   // Index 0 is the present lit level; index k is that level k cycles ago.
   assign hv = {q.hist, ~blank_s};

   genvar n;
   generate
      for (n = 0; n < NCH; n++)
      begin : g_ch
         localparam int DN = lsd_pkg::lsd_dly(n);
         assign en_w[n] = q.onoff[n] & hv[DN];
         assign trim_w[n*TW +: TW] = en_w[n] ? q.trim[n*TW +: TW] : {TW{1'b0}};
         assign pend[n] = q.onoff[n] & (|hv[DN:0]);
         assign open_led_flag[n]  = ~blank_s & q.onoff[n] & out_low_s[n];
      end
   endgenerate

   always_comb
   begin
      d             = q;
      d.strobe_prev = strobe_s;
      d.hist        = hv[MAXD-1:0];
      if (onoff_take)
         d.onoff = lk_onoff;
      if (trim_take)
         d.trim = lk_trim;
      d.sink_en     = en_w;
      d.sink_trim   = trim_w;
      d.precharge   = blank_s & ~(|pend);
      d.err_oe      = overt_s | (|open_led_flag);
   end

   always_ff @(posedge i_ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q           <= '0;
         q.onoff     <= lsd_pkg::ONOFF_RST;
         q.trim      <= lsd_pkg::TRIM_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_sink_en         = q.sink_en;
   assign o_sink_trim       = q.sink_trim;
   assign o_precharge_on    = q.precharge;
   assign o_error_line_n_o  = 1'b0;
   assign o_error_line_n_oe = q.err_oe;

   default clocking ref_cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_onoff_take;
      strobe_s && !q.strobe_prev && mode_s == lsd_pkg::LSD_MODE_ONOFF;
   endsequence

   sequence s_trim_take;
      strobe_s && mode_s == lsd_pkg::LSD_MODE_TRIM;
   endsequence

   sequence s_blank_high_run;
      blank_s [*7];
   endsequence

   sequence s_lit_run_ch15;
      (!blank_s && q.onoff[15]) [*8];
   endsequence

   a_onoff_latch_copy: assert property (
      s_onoff_take |=> q.onoff == $past(lk_onoff))
      else $error("On/off register missed the strobe edge.");

   a_onoff_hold_value: assert property (
      !onoff_take |=> $stable(q.onoff))
      else $error("On/off register changed without a strobe edge.");

   a_latch_any_blank: assert property (
      blank_s ##0 s_onoff_take |=> q.onoff == $past(lk_onoff))
      else $error("On/off latch refused while blanked.");

   a_trim_follow_level: assert property (
      s_trim_take |=> q.trim == $past(lk_trim))
      else $error("Trim register did not follow during strobe.");

   a_trim_hold_low: assert property (
      !trim_take |=> $stable(q.trim))
      else $error("Trim register moved with strobe low.");

   a_ch0_no_delay: assert property (
      o_sink_en[0] == $past(q.onoff[0] && !blank_s))
      else $error("Channel 0 did not follow blank at once.");

   a_ch15_late_on: assert property (
      s_blank_high_run ##1 !blank_s |=> !o_sink_en[15] [*6])
      else $error("Channel 15 turned on before its delay.");

   a_ch15_lit: assert property (
      s_lit_run_ch15 |=> o_sink_en[15])
      else $error("Channel 15 not lit after its delay.");

   a_precharge_off: assert property (
      $fell(blank_s) |=> !o_precharge_on)
      else $error("Precharge stayed on after blank fell.");

   a_precharge_excl: assert property (
      o_precharge_on |-> o_sink_en == '0)
      else $error("Precharge on while a channel sinks current.");

   a_precharge_prompt: assert property (
      blank_s && $fell(|pend) |=> o_precharge_on)
      else $error("Precharge late after last output off.");

   a_trim_gate: assert property (
      !o_sink_en[1] |-> o_sink_trim[TW +: TW] == '0)
      else $error("Trim code driven on a dark channel.");

   a_error_overtemp: assert property (
      overt_s |=> o_error_line_n_oe)
      else $error("Error line not pulled on overtemperature.");

   a_error_masked: assert property (
      (blank_s && !overt_s) [*2] |-> !o_error_line_n_oe)
      else $error("Error line pulled while blanked and cool.");

   // Per-channel checks of stagger, gating, trim codes and open detection.
   generate
      for (n = 0; n < NCH; n++)
      begin : g_chk
         localparam int PD = lsd_pkg::lsd_dly(n) + 1;

         a_ch_stagger: assert property (
            o_sink_en[n] == ($past(q.onoff[n]) && !$past(blank_s, PD)))
            else $error("Channel lost its staggered timing.");

         a_ch_onoff_gate: assert property (
            !$past(q.onoff[n]) |-> !o_sink_en[n])
            else $error("Channel lit with its on/off bit clear.");

         a_ch_blank_dark: assert property (
            $past(blank_s, PD) |-> !o_sink_en[n])
            else $error("Channel lit after its delayed blank.");

         a_ch_lit_low: assert property (
            $past(q.onoff[n]) && !$past(blank_s, PD) |-> o_sink_en[n])
            else $error("Channel dark after its delayed unblank.");

         a_ch_trim_dark: assert property (
            !o_sink_en[n] |-> o_sink_trim[n*TW +: TW] == '0)
            else $error("Trim code driven on a dark channel.");

         a_ch_trim_code: assert property (
            o_sink_en[n] |-> o_sink_trim[n*TW +: TW] == $past(q.trim[n*TW +: TW]))
            else $error("Lit channel shows a stale trim code.");

         a_ch_open_flag: assert property (
            $past(!blank_s && q.onoff[n] && out_low_s[n]) |-> o_error_line_n_oe)
            else $error("Open output did not pull the error line.");
      end
   endgenerate

   a_dark_after_blank: assert property (
      s_blank_high_run |=> o_sink_en == '0)
      else $error("A channel still sinks current after blanking.");

   a_precharge_after: assert property (
      s_blank_high_run |=> o_precharge_on)
      else $error("Precharge not on after all outputs went dark.");

   a_precharge_low: assert property (
      !$past(blank_s) |-> !o_precharge_on)
      else $error("Precharge on while not blanked.");

   a_precharge_rise: assert property (
      $rose(o_precharge_on) |-> $past(blank_s))
      else $error("Precharge rose without blanking.");

   a_precharge_idle: assert property (
      $past(q.onoff) == '0 |-> o_precharge_on == $past(blank_s))
      else $error("Precharge did not follow blank with all channels off.");

   a_precharge_hold: assert property (
      o_precharge_on && blank_s |=> o_precharge_on)
      else $error("Precharge dropped while still blanked.");

   a_error_quiet: assert property (
      $past(!overt_s && (blank_s || (q.onoff & out_low_s) == '0)) |-> !o_error_line_n_oe)
      else $error("Error line pulled with no fault.");

   a_error_temp_blank: assert property (
      blank_s && overt_s |=> o_error_line_n_oe)
      else $error("Overtemperature masked by blanking.");

   a_onoff_mode_gate: assert property (
      mode_s == lsd_pkg::LSD_MODE_TRIM |=> $stable(q.onoff))
      else $error("On/off register moved in trim mode.");

   a_trim_mode_gate: assert property (
      mode_s == lsd_pkg::LSD_MODE_ONOFF |=> $stable(q.trim))
      else $error("Trim register moved in on/off mode.");

   a_onoff_trim_hold: assert property (
      s_onoff_take |=> $stable(q.trim))
      else $error("On/off latch disturbed the trim register.");

   a_latch_blank_low: assert property (
      !blank_s ##0 s_onoff_take |=> q.onoff == $past(lk_onoff))
      else $error("On/off latch refused while unblanked.");

   a_onoff_edge_only: assert property (
      strobe_s && q.strobe_prev |=> $stable(q.onoff))
      else $error("On/off register followed a steady strobe.");

   a_trim_strobe_low: assert property (
      !strobe_s |=> $stable(q.trim))
      else $error("Trim register moved with the strobe low.");

   a_ch0_off_prompt: assert property (
      $rose(blank_s) |=> !o_sink_en[0])
      else $error("Channel 0 late to switch off.");

   a_ch0_on_prompt: assert property (
      $fell(blank_s) && q.onoff[0] |=> o_sink_en[0])
      else $error("Channel 0 late to switch on.");

   a_ch15_late_off: assert property (
      s_lit_run_ch15 ##1 q.onoff[15] [*6] |=> o_sink_en[15])
      else $error("Channel 15 switched off before its delay.");

endmodule // lsd_top
`default_nettype wire

/* bench/lsd_ctrl_model.sv */
// Behavioural model of the controller that drives the serial shift link.
`timescale 1ns/1ps
`default_nettype none
module lsd_ctrl_model (
   output logic o_shift_clk,
   output logic o_serial_in,
   output logic o_mode
);
   initial
   begin
      o_shift_clk = 1'b0;
      o_serial_in = 1'b0;
      o_mode      = 1'b0;
   end

   // Shifts n bits of d, top bit first; the 12 ns clock stands still between frames.
   task automatic send(input logic m, input logic [111:0] d, input int n);
      o_mode = m;
      #6;
      for (int i = n - 1; i >= 0; i--)
      begin
         o_serial_in = d[i];
         #6 o_shift_clk = 1'b1;
         #6 o_shift_clk = 1'b0;
      end
      o_serial_in = ~o_serial_in;
      #6;
   endtask
endmodule // lsd_ctrl_model
`default_nettype wire

/* bench/testbench.sv */
// Self-checking testbench of the LED sink driver control logic.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic           i_ref_clk;
   logic           i_rstn;
   logic           i_latch_strobe;
   logic           i_blank;
   logic           i_overtemp_flag;
   logic [15:0]    i_out_low;
   wire            shift_clk;
   wire            serial_in;
   wire            mode;
   logic           o_serial_out;
   logic [15:0]    o_sink_en;
   logic [111:0]   o_sink_trim;
   logic           o_precharge_on;
   logic           err_o;
   logic           err_oe;
   int             err_count;
   int             n_checks;
   localparam logic [111:0] TP = {8{14'h1A5B}};

   lsd_ctrl_model i_lsd_ctrl_model (.o_shift_clk(shift_clk), .o_serial_in(serial_in),
      .o_mode(mode));
   lsd_top i_lsd_top (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_shift_clk(shift_clk),
      .i_serial_in(serial_in), .i_mode(mode), .i_latch_strobe(i_latch_strobe),
      .i_blank(i_blank), .i_overtemp_flag(i_overtemp_flag), .i_out_low(i_out_low),
      .o_serial_out(o_serial_out), .o_sink_en(o_sink_en), .o_sink_trim(o_sink_trim),
      .o_precharge_on(o_precharge_on), .o_error_line_n_o(err_o),
      .o_error_line_n_oe(err_oe));

   initial
   begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   task automatic check(input string name, input logic [111:0] got, input logic [111:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   task automatic set_blank(input logic b);
      @(posedge i_ref_clk);
      i_blank <= b;
   endtask

   task automatic pulse_strobe;
      cyc(3);
      i_latch_strobe <= 1'b1;
      cyc(3);
      i_latch_strobe <= 1'b0;
      cyc(4);
   endtask

   // A 24-bit frame spills eight bits onward and leaves the last sixteen latched.
   task automatic t_chain;
      i_lsd_ctrl_model.send(1'b0, 112'h18000, 24);
      check("serial_out", o_serial_out, 112'h1);
      pulse_strobe();
      set_blank(1'b0);
      cyc(12);
      check("onoff chain", o_sink_en, 112'h8000);
      set_blank(1'b1);
      cyc(12);
   endtask

   // Records the cycle at which each channel and the precharge switch change.
   task automatic t_stagger;
      int t_ch[16];
      int t_pc;
      i_lsd_ctrl_model.send(1'b0, 112'hFFFF, 16);
      pulse_strobe();
      for (int ph = 0; ph < 2; ph++)
      begin
         for (int n = 0; n < 16; n++)
            t_ch[n] = -1;
         t_pc = -1;
         set_blank(ph == 1);
         for (int c = 0; c < 14; c++)
         begin
            @(negedge i_ref_clk);
            for (int n = 0; n < 16; n++)
               if (o_sink_en[n] === (ph == 0) && t_ch[n] < 0)
                  t_ch[n] = c;
            if (o_precharge_on === (ph == 1) && t_pc < 0)
               t_pc = c;
            if (ph == 1 && o_sink_en != 16'h0000)
               check("precharge early", o_precharge_on, 112'h0);
         end
         for (int n = 0; n < 16; n++)
            check("stagger", 112'(t_ch[n] - t_ch[0]), 112'((n * 20) / 50));
         if (ph == 0)
            check("precharge off", 112'(t_pc), 112'(t_ch[0]));
         else
            check("precharge on", 112'(t_pc), 112'(t_ch[15]));
      end
   endtask

   // A two-cycle blanking gap lights every channel for two cycles.
   task automatic t_pulse;
      int lit[16];
      for (int n = 0; n < 16; n++)
         lit[n] = 0;
      set_blank(1'b0);
      cyc(1);
      set_blank(1'b1);
      for (int c = 0; c < 14; c++)
      begin
         @(negedge i_ref_clk);
         for (int n = 0; n < 16; n++)
            lit[n] += (o_sink_en[n] === 1'b1);
      end
      for (int n = 0; n < 16; n++)
         check("lit cycles", 112'(lit[n]), 112'h2);
   endtask

   task automatic t_trim;
      i_lsd_ctrl_model.send(1'b1, TP, 112);
      pulse_strobe();
      set_blank(1'b0);
      cyc(12);
      check("trim", o_sink_trim, TP);
      i_lsd_ctrl_model.send(1'b1, ~TP, 112);
      cyc(6);
      check("trim hold", o_sink_trim, TP);
      i_lsd_ctrl_model.send(1'b0, 112'h0001, 16);
      pulse_strobe();
      check("trim dark", o_sink_trim, {105'h0, TP[6:0]});
      set_blank(1'b1);
      cyc(12);
   endtask

   task automatic t_error;
      i_out_low <= 16'hFFFF;
      cyc(5);
      check("err blank", err_oe, 112'h0);
      i_overtemp_flag <= 1'b1;
      cyc(5);
      check("err temp", err_oe, 112'h1);
      i_overtemp_flag <= 1'b0;
      i_out_low       <= 16'hFFFE;
      set_blank(1'b0);
      cyc(12);
      check("err off ch", err_oe, 112'h0);
      i_out_low <= 16'h0001;
      cyc(5);
      check("err open", err_oe, 112'h1);
      check("err level", err_o, 112'h0);
   endtask

   initial
   begin
      err_count       = 0;
      n_checks        = 0;
      i_rstn          = 1'b0;
      i_latch_strobe  = 1'b0;
      i_blank         = 1'b1;
      i_overtemp_flag = 1'b0;
      i_out_low       = 16'h0000;
      cyc(16);
      i_rstn <= 1'b1;
      cyc(4);
      i_lsd_ctrl_model.send(1'b0, 112'h0, 2);
      t_chain();
      t_stagger();
      t_pulse();
      t_trim();
      t_error();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
